// >>> hw/irq_bank_pkg.sv
package irq_bank_pkg;

  // Register port geometry
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned PRIO_W = 3;
  localparam int unsigned SRC_W  = 4;

  // Register word addresses on the plain register port
  localparam logic [2:0] REG_TRAP_STATUS  = 3'h0;
  localparam logic [2:0] REG_VECTOR_EDGE  = 3'h1;
  localparam logic [2:0] REG_FLAGS_0      = 3'h2;
  localparam logic [2:0] REG_FLAGS_1      = 3'h3;
  localparam logic [2:0] REG_FLAGS_3      = 3'h4;
  localparam logic [2:0] REG_FLAGS_4      = 3'h5;
  localparam logic [2:0] REG_ENABLES_0    = 3'h6;
  localparam logic [2:0] REG_PRIORITY_0   = 3'h7;

  // Implemented-bit masks; other positions read zero and ignore writes, bar the hold bit 14 of the vector register, which reads the live status
  localparam logic [15:0] TRAP_MASK       = 16'h0006;
  localparam logic [15:0] VECTOR_WR_MASK  = 16'h8007;
  localparam logic [15:0] FLAGS_0_MASK    = 16'h3FEF;
  localparam logic [15:0] FLAGS_1_MASK    = 16'h20DB;
  localparam logic [15:0] FLAGS_3_MASK    = 16'h8600;
  localparam logic [15:0] FLAGS_4_MASK    = 16'h0602;
  localparam logic [15:0] ENABLES_0_MASK  = 16'h3FEF;
  localparam logic [15:0] PRIORITY_0_MASK = 16'h7777;

  // Values after reset
  localparam logic [15:0] REG_RESET        = 16'h0000;
  localparam logic [15:0] PRIORITY_0_RESET = 16'h4444;

  // Trap status and vector/edge control bit positions
  localparam int unsigned STACK_FAULT_BIT   = 2;
  localparam int unsigned CLOCK_FAIL_BIT    = 1;
  localparam int unsigned ALT_TABLE_BIT     = 15;
  localparam int unsigned HOLD_INSTR_BIT    = 14;
  localparam int unsigned EXT_EDGE_LSB      = 0;
  localparam int unsigned EXT_COUNT         = 3;

  // First flag/enable register positions
  localparam int unsigned ADC_DONE_BIT  = 13;
  localparam int unsigned UART_TX_BIT   = 12;
  localparam int unsigned UART_RX_BIT   = 11;
  localparam int unsigned SPI_EVENT_BIT = 10;
  localparam int unsigned SPI_FAULT_BIT = 9;
  localparam int unsigned TIMER3_BIT    = 8;
  localparam int unsigned TIMER2_BIT    = 7;
  localparam int unsigned COMPARE2_BIT  = 6;
  localparam int unsigned CAPTURE2_BIT  = 5;
  localparam int unsigned TIMER1_BIT    = 3;
  localparam int unsigned COMPARE1_BIT  = 2;
  localparam int unsigned CAPTURE1_BIT  = 1;
  localparam int unsigned EXT0_BIT      = 0;

  // Second flag register positions
  localparam int unsigned EXT2_BIT       = 13;
  localparam int unsigned CAPTURE8_BIT   = 7;
  localparam int unsigned CAPTURE7_BIT   = 6;
  localparam int unsigned EXT1_BIT       = 4;
  localparam int unsigned PIN_CHANGE_BIT = 3;
  localparam int unsigned I2C_MASTER_BIT = 1;
  localparam int unsigned I2C_SLAVE_BIT  = 0;

  // Third and fourth flag register positions
  localparam int unsigned PWM1_FAULT_A_BIT = 15;
  localparam int unsigned QUAD_ENCODER_BIT = 10;
  localparam int unsigned PWM1_EVENT_BIT   = 9;
  localparam int unsigned PWM2_FAULT_A_BIT = 10;
  localparam int unsigned PWM2_ERROR_BIT   = 9;
  localparam int unsigned UART_ERROR_BIT   = 1;

  // Priority codes and field layout
  localparam logic [2:0]  PRIO_OFF       = 3'h0;
  localparam logic [2:0]  PRIO_DEFAULT   = 3'h4;
  localparam int unsigned PRIO_FIELD_SPAN = 4;
  localparam int unsigned PRIO_SOURCES   = 4;

  // Cycles for a pin level to pass the synchroniser before edges count
  localparam logic [1:0] SYNC_WARM_DONE = 2'h3;

endpackage

// >>> hw/ext_edge_detect.sv
`timescale 1ns/1ps
`default_nettype none

module ext_edge_detect #(
  parameter int unsigned N = irq_bank_pkg::EXT_COUNT
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         reset_n,
  // Raw pins and per-pin polarity select (1 = falling edge)
  input  wire logic [N-1:0] extPin,
  input  wire logic [N-1:0] fallingSel,
  // One-cycle pulse per detected edge
  output logic      [N-1:0] edgePulse
);

  // Whole state of the detector
  typedef struct packed {
    logic [N-1:0] sync1;   // First synchroniser stage, read only by sync2
    logic [N-1:0] sync2;   // Second synchroniser stage
    logic [N-1:0] last;    // Previous settled level
    logic [1:0]   warm;    // Counts settle cycles after reset
    logic [N-1:0] pulse;   // Registered edge pulses
  } state_s;

  state_s cur_q;
  state_s nxt_d;

  // Next-state logic: edges only count once the pipeline holds real levels,
  // so a pin already high at reset release gives no false request
  always_comb begin
    nxt_d       = cur_q;
    nxt_d.sync1 = extPin;
    nxt_d.sync2 = cur_q.sync1;
    nxt_d.last  = cur_q.sync2;
    nxt_d.pulse = '0;
    if (cur_q.warm != irq_bank_pkg::SYNC_WARM_DONE) begin
      nxt_d.warm = cur_q.warm + 2'h1;
    end else begin
      for (int i = 0; i < N; i++) begin
        // Polarity 1 picks the falling edge, 0 the rising one
        if (fallingSel[i]) begin
          nxt_d.pulse[i] = cur_q.last[i] & ~cur_q.sync2[i];
        end else begin
          nxt_d.pulse[i] = ~cur_q.last[i] & cur_q.sync2[i];
        end
      end
    end
  end

  // State register with synchronous reset
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cur_q <= '0;
    end else begin
      cur_q <= nxt_d;
    end
  end

  assign edgePulse = cur_q.pulse;

endmodule

`default_nettype wire

// >>> hw/interrupt_flag_enable_bank.sv
// What this block does
// - Vector table select bit chooses alternate table
// - Hold-instruction status bit is read-only
// - Edge polarity: 1 falling, 0 rising
// - Unimplemented bits read zero, ignore writes
// - Stack fault trap sets its status bit
// - Clock failure trap sets its status bit
// - First flags upper byte source positions
// - First flags lower byte source positions
// - Second flags register source positions
// - Third flags register source positions
// - Fourth flags register source positions
// - First enables mirror first flag positions
// - Enable bit gates request forwarding
// - Priority 111 highest, 000 disables source
`timescale 1ns/1ps
`default_nettype none

module interrupt_flag_enable_bank (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // Register port
  input  wire logic [2:0]  regAddr,
  input  wire logic [15:0] regWrData,
  input  wire logic        regWrEn,
  input  wire logic        regRdEn,
  output logic      [15:0] regRdData,
  // Core status and trap events (one-cycle pulses, same clock)
  input  wire logic        irqHoldInstrActive,
  input  wire logic        stackFaultTrap,
  input  wire logic        clockFailureTrap,
  // External interrupt pins (asynchronous)
  input  wire logic        ext0Pin,
  input  wire logic        ext1Pin,
  input  wire logic        ext2Pin,
  // Peripheral events for the first flag register
  input  wire logic        adcDoneEvent,
  input  wire logic        uartTxEvent,
  input  wire logic        uartRxEvent,
  input  wire logic        spiEvent,
  input  wire logic        spiFaultEvent,
  input  wire logic        timer3Event,
  input  wire logic        timer2Event,
  input  wire logic        compare2Event,
  input  wire logic        capture2Event,
  input  wire logic        timer1Event,
  input  wire logic        compare1Event,
  input  wire logic        capture1Event,
  // Peripheral events for the second flag register
  input  wire logic        capture8Event,
  input  wire logic        capture7Event,
  input  wire logic        pinChangeEvent,
  input  wire logic        i2cMasterEvent,
  input  wire logic        i2cSlaveEvent,
  // Peripheral events for the third and fourth flag registers
  input  wire logic        pwm1FaultAEvent,
  input  wire logic        quadEncoderEvent,
  input  wire logic        pwm1Event,
  input  wire logic        pwm2FaultAEvent,
  input  wire logic        pwm2ErrorEvent,
  input  wire logic        uartErrorEvent,
  // Request to the core exception logic
  output logic             requestPending,
  output logic      [2:0]  requestLevel,
  output logic      [3:0]  requestSource,
  output logic             altVectorTable
);

  // Whole state of the block
  typedef struct packed {
    logic [15:0] trapStatus;   // Trap status bits
    logic [15:0] vectorEdge;   // Table select and edge polarity bits
    logic [15:0] flags0;       // First request flags
    logic [15:0] flags1;       // Second request flags
    logic [15:0] flags3;       // Third request flags
    logic [15:0] flags4;       // Fourth request flags
    logic [15:0] enables0;     // First request enables
    logic [15:0] priority0;    // Priority fields of the four lowest sources
    logic [15:0] rdData;       // Read answer, valid the cycle after a read
    logic        pending;      // A forwarded request exists
    logic [2:0]  level;        // Its priority level
    logic [3:0]  source;       // Its bit position in the first flags
    logic        altTable;     // Vector table select driven to the core
  } state_s;

  state_s cur_q;
  state_s nxt_d;

  // Synchronised external edges, one pulse per detected edge
  logic [2:0] extEdge;

  // Set vectors built from the event inputs
  logic [15:0] trapSet;
  logic [15:0] flags0Set;
  logic [15:0] flags1Set;
  logic [15:0] flags3Set;
  logic [15:0] flags4Set;

  // Register read view
  logic [15:0] readView;

  // Arbitration result
  logic        bestValid;
  logic [2:0]  bestLevel;
  logic [3:0]  bestSource;

  // Pin synchroniser and edge detection with software polarity
  // Pin edges are ignored for a short warm-up after reset
  ext_edge_detect #(
    .N (irq_bank_pkg::EXT_COUNT)
  ) u_ext_edge (
    .sys_clk    (sys_clk),
    .reset_n    (reset_n),
    .extPin     ({ext2Pin, ext1Pin, ext0Pin}),
    .fallingSel (cur_q.vectorEdge[irq_bank_pkg::EXT_EDGE_LSB +: 3]),
    .edgePulse  (extEdge)
  );

  // Priority code of one first-flags source; only four have fields here,
  // the rest run at the fixed default level
  function automatic logic [2:0] srcPriority(input logic [15:0] prio, input int unsigned idx);
    logic [2:0] code;
    code = irq_bank_pkg::PRIO_DEFAULT;
    if (idx < irq_bank_pkg::PRIO_SOURCES) begin
      code = prio[idx*irq_bank_pkg::PRIO_FIELD_SPAN +: 3];
    end
    return code;
  endfunction

  // Gather event pulses into per-register set vectors
  always_comb begin
    trapSet   = '0;
    flags0Set = '0;
    flags1Set = '0;
    flags3Set = '0;
    flags4Set = '0;
    // Trap status events
    trapSet[irq_bank_pkg::STACK_FAULT_BIT] = stackFaultTrap;
    trapSet[irq_bank_pkg::CLOCK_FAIL_BIT]  = clockFailureTrap;

    // First flags, upper byte
    flags0Set[irq_bank_pkg::ADC_DONE_BIT]  = adcDoneEvent;
    flags0Set[irq_bank_pkg::UART_TX_BIT]   = uartTxEvent;
    flags0Set[irq_bank_pkg::UART_RX_BIT]   = uartRxEvent;
    flags0Set[irq_bank_pkg::SPI_EVENT_BIT] = spiEvent;
    flags0Set[irq_bank_pkg::SPI_FAULT_BIT] = spiFaultEvent;
    flags0Set[irq_bank_pkg::TIMER3_BIT]    = timer3Event;

    // First flags, lower byte; bit 4 has no source
    flags0Set[irq_bank_pkg::TIMER2_BIT]    = timer2Event;
    flags0Set[irq_bank_pkg::COMPARE2_BIT]  = compare2Event;
    flags0Set[irq_bank_pkg::CAPTURE2_BIT]  = capture2Event;
    flags0Set[irq_bank_pkg::TIMER1_BIT]    = timer1Event;
    flags0Set[irq_bank_pkg::COMPARE1_BIT]  = compare1Event;
    flags0Set[irq_bank_pkg::CAPTURE1_BIT]  = capture1Event;
    flags0Set[irq_bank_pkg::EXT0_BIT]      = extEdge[0];

    // Second flags; ext1 and ext2 land here
    flags1Set[irq_bank_pkg::EXT2_BIT]       = extEdge[2];
    flags1Set[irq_bank_pkg::CAPTURE8_BIT]   = capture8Event;
    flags1Set[irq_bank_pkg::CAPTURE7_BIT]   = capture7Event;
    flags1Set[irq_bank_pkg::EXT1_BIT]       = extEdge[1];
    flags1Set[irq_bank_pkg::PIN_CHANGE_BIT] = pinChangeEvent;
    flags1Set[irq_bank_pkg::I2C_MASTER_BIT] = i2cMasterEvent;
    flags1Set[irq_bank_pkg::I2C_SLAVE_BIT]  = i2cSlaveEvent;

    // Third flags
    flags3Set[irq_bank_pkg::PWM1_FAULT_A_BIT] = pwm1FaultAEvent;
    flags3Set[irq_bank_pkg::QUAD_ENCODER_BIT] = quadEncoderEvent;
    flags3Set[irq_bank_pkg::PWM1_EVENT_BIT]   = pwm1Event;

    // Fourth flags
    flags4Set[irq_bank_pkg::PWM2_FAULT_A_BIT] = pwm2FaultAEvent;
    flags4Set[irq_bank_pkg::PWM2_ERROR_BIT]   = pwm2ErrorEvent;
    flags4Set[irq_bank_pkg::UART_ERROR_BIT]   = uartErrorEvent;
  end

  // Read multiplexer; unmapped positions are masked to zero
  // All eight addresses decode, so no default
  always_comb begin
    unique case (regAddr)
      irq_bank_pkg::REG_TRAP_STATUS: begin
        // Two trap bits only
        readView = cur_q.trapStatus & irq_bank_pkg::TRAP_MASK;
      end

      irq_bank_pkg::REG_VECTOR_EDGE: begin
        // The hold bit is the live core status, never a stored value
        readView = cur_q.vectorEdge & irq_bank_pkg::VECTOR_WR_MASK;
        readView[irq_bank_pkg::HOLD_INSTR_BIT] = irqHoldInstrActive;
      end

      irq_bank_pkg::REG_FLAGS_0: begin
        // Bits 15, 14 and 4 read zero
        readView = cur_q.flags0 & irq_bank_pkg::FLAGS_0_MASK;
      end

      irq_bank_pkg::REG_FLAGS_1: begin
        // Seven sources, rest zero
        readView = cur_q.flags1 & irq_bank_pkg::FLAGS_1_MASK;
      end

      irq_bank_pkg::REG_FLAGS_3: begin
        // Three sources, upper byte
        readView = cur_q.flags3 & irq_bank_pkg::FLAGS_3_MASK;
      end

      irq_bank_pkg::REG_FLAGS_4: begin
        // Three sources, both bytes
        readView = cur_q.flags4 & irq_bank_pkg::FLAGS_4_MASK;
      end

      irq_bank_pkg::REG_ENABLES_0: begin
        // Same layout as the first flags
        readView = cur_q.enables0 & irq_bank_pkg::ENABLES_0_MASK;
      end

      irq_bank_pkg::REG_PRIORITY_0: begin
        // Four 3-bit fields
        readView = cur_q.priority0 & irq_bank_pkg::PRIORITY_0_MASK;
      end
    endcase
  end

  // Arbitration over the first flags: highest level wins, a strict compare
  // keeps the lowest bit position on ties so the order is fixed
  // Only the first flags are forwarded; the others are status only
  always_comb begin
    logic [2:0] code;
    code       = irq_bank_pkg::PRIO_OFF;
    bestValid  = 1'b0;
    bestLevel  = irq_bank_pkg::PRIO_OFF;
    bestSource = '0;
    for (int i = 0; i < 16; i++) begin
      code = srcPriority(cur_q.priority0, i);
      // Only flagged, enabled sources with a non-zero code are forwarded
      if (cur_q.flags0[i] && cur_q.enables0[i]
          && (code != irq_bank_pkg::PRIO_OFF)
          && (code > bestLevel)) begin
        bestValid  = 1'b1;
        bestLevel  = code;
        bestSource = SRC_CAST(i);
      end
    end
  end

  // Index-to-source width conversion kept in one place
  // The loop stops at 15, so four bits always hold it
  function automatic logic [3:0] SRC_CAST(input int unsigned idx);
    return idx[3:0];
  endfunction

  // Next-state logic; within each register a hardware set is OR-ed after
  // the software write, so an event in the clearing cycle is never lost
  always_comb begin
    nxt_d = cur_q;
    // Software writes land only on implemented positions
    if (regWrEn) begin
      unique case (regAddr)
        irq_bank_pkg::REG_TRAP_STATUS: begin
          // Software may set or clear a trap bit
          nxt_d.trapStatus = regWrData & irq_bank_pkg::TRAP_MASK;
        end

        irq_bank_pkg::REG_VECTOR_EDGE: begin
          // Hold bit is excluded from the mask, so writing it does nothing
          nxt_d.vectorEdge = regWrData & irq_bank_pkg::VECTOR_WR_MASK;
        end

        irq_bank_pkg::REG_FLAGS_0: begin
          // Writing 0 is how a handler clears
          nxt_d.flags0 = regWrData & irq_bank_pkg::FLAGS_0_MASK;
        end

        irq_bank_pkg::REG_FLAGS_1: begin
          nxt_d.flags1 = regWrData & irq_bank_pkg::FLAGS_1_MASK;
        end

        irq_bank_pkg::REG_FLAGS_3: begin
          nxt_d.flags3 = regWrData & irq_bank_pkg::FLAGS_3_MASK;
        end

        irq_bank_pkg::REG_FLAGS_4: begin
          nxt_d.flags4 = regWrData & irq_bank_pkg::FLAGS_4_MASK;
        end

        irq_bank_pkg::REG_ENABLES_0: begin
          // Takes effect on the next arbitration
          nxt_d.enables0 = regWrData & irq_bank_pkg::ENABLES_0_MASK;
        end

        irq_bank_pkg::REG_PRIORITY_0: begin
          // Code 0 parks a source
          nxt_d.priority0 = regWrData & irq_bank_pkg::PRIORITY_0_MASK;
        end
      endcase
    end

    // Flags set by their events whatever the enables say, and stay set
    nxt_d.trapStatus = nxt_d.trapStatus | trapSet;
    nxt_d.flags0     = nxt_d.flags0 | flags0Set;
    nxt_d.flags1     = nxt_d.flags1 | flags1Set;
    nxt_d.flags3     = nxt_d.flags3 | flags3Set;
    nxt_d.flags4     = nxt_d.flags4 | flags4Set;

    // Read answer stands only in the cycle after the read strobe
    nxt_d.rdData = regRdEn ? readView : irq_bank_pkg::REG_RESET;

    // Request outputs follow the arbitration of the present state
    nxt_d.pending  = bestValid;
    nxt_d.level    = bestLevel;
    nxt_d.source   = bestSource;
    // Table select reaches the core one edge after its write
    nxt_d.altTable = cur_q.vectorEdge[irq_bank_pkg::ALT_TABLE_BIT];
  end

  // State register with synchronous reset
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      // Priority fields leave reset at the middle level
      cur_q           <= '0;
      cur_q.priority0 <= irq_bank_pkg::PRIORITY_0_RESET;
    end else begin
      cur_q <= nxt_d;
    end
  end

  // Outputs straight from the state register
  // A zero read answer outside its cycle keeps a bus OR clean
  assign regRdData      = cur_q.rdData;
  assign requestPending = cur_q.pending;
  assign requestLevel   = cur_q.level;
  assign requestSource  = cur_q.source;
  assign altVectorTable = cur_q.altTable;

endmodule

`default_nettype wire

// >>> bench/irq_bank_checker.sv
`timescale 1ns/1ps
`default_nettype none

module irq_bank_checker (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // Register port
  input  wire logic [2:0]  regAddr,
  input  wire logic [15:0] regWrData,
  input  wire logic        regWrEn,
  input  wire logic        regRdEn,
  input  wire logic [15:0] regRdData,
  // Core status and traps
  input  wire logic        irqHoldInstrActive,
  input  wire logic        stackFaultTrap,
  input  wire logic        clockFailureTrap,
  // Request toward the core
  input  wire logic        requestPending,
  input  wire logic [2:0]  requestLevel,
  input  wire logic [3:0]  requestSource,
  input  wire logic        altVectorTable
);
  // One clock domain, so one default clocking and reset
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // Trap pulse, then a read of the trap register two edges on
  sequence stackThenRead;
    stackFaultTrap ##2 (regRdEn && regAddr == 3'h0);
  endsequence
  sequence clockThenRead;
    clockFailureTrap ##2 (regRdEn && regAddr == 3'h0);
  endsequence
  // Enables written to zero and left alone for a cycle
  sequence enablesCleared;
    (regWrEn && regAddr == 3'h6 && regWrData == 16'h0000) ##1 !(regWrEn && regAddr == 3'h6);
  endsequence
  // Table select copy follows the written bit; a second write in between would move it
  property altFollows;
    logic v;
    (regWrEn && regAddr == 3'h1, v = regWrData[15]) ##1 !(regWrEn && regAddr == 3'h1) |-> ##1 altVectorTable == v;
  endproperty

  a_flags0_unimpl_zero: assert property (regRdEn && regAddr == 3'h2 |=> (regRdData & 16'hC010) == 16'h0000)
    else $error("flags0 unimplemented bit set");
  a_vector_unimpl_zero: assert property (regRdEn && regAddr == 3'h1 |=> (regRdData & 16'h3FF8) == 16'h0000)
    else $error("vector reg unimplemented bit set");
  a_flags3_unimpl_zero: assert property (regRdEn && regAddr == 3'h4 |=> (regRdData & 16'h79FF) == 16'h0000)
    else $error("flags3 unimplemented bit set");
  a_hold_bit_live: assert property (regRdEn && regAddr == 3'h1 |=> regRdData[14] == $past(irqHoldInstrActive))
    else $error("hold status bit wrong");
  a_stack_trap_set: assert property (stackThenRead |=> regRdData[2])
    else $error("stack trap bit not set");
  a_clock_trap_set: assert property (clockThenRead |=> regRdData[1])
    else $error("clock trap bit not set");
  a_alt_table_follows: assert property (altFollows)
    else $error("table select output wrong");
  a_enables_off_quiet: assert property (enablesCleared |-> ##1 !requestPending)
    else $error("request with all enables off");
  a_level_nonzero: assert property (requestPending |-> requestLevel != 3'h0)
    else $error("request forwarded at level zero");
  a_source_implemented: assert property (requestPending |-> requestSource != 4'h4 && requestSource <= 4'hD)
    else $error("request from unimplemented position");
endmodule

bind interrupt_flag_enable_bank irq_bank_checker u_irq_bank_checker (
  .sys_clk, .reset_n, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData,
  .irqHoldInstrActive, .stackFaultTrap, .clockFailureTrap,
  .requestPending, .requestLevel, .requestSource, .altVectorTable
);

`default_nettype wire

// >>> bench/irq_source_model.sv
`timescale 1ns/1ps
`default_nettype none

module irq_source_model (
  // Clock
  input  wire logic        sys_clk,
  // Peripheral and trap events, low between pulses
  output logic      [24:0] eventLine,
  // External pin levels and core hold status
  output logic      [2:0]  extPinLevel,
  output logic             holdActive
);
  // Everything quiet from time zero
  initial begin
    eventLine   = '0;
    extPinLevel = '0;
    holdActive  = 1'b0;
  end

  // One-cycle event, launched just after a rising edge
  task automatic fire(input int idx);
    @(posedge sys_clk);
    eventLine[idx] <= 1'b1;
    @(posedge sys_clk);
    eventLine[idx] <= 1'b0;
  endtask

  // Pins are asynchronous; moved on an edge only for a tidy run
  task automatic set_pin(input int idx, input logic lvl);
    @(posedge sys_clk);
    extPinLevel[idx] <= lvl;
  endtask
endmodule

`default_nettype wire

// >>> bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic        sys_clk;
  logic        reset_n;
  logic [2:0]  regAddr;
  logic [15:0] regWrData;
  logic        regWrEn;
  logic        regRdEn;
  logic [15:0] regRdData;
  logic        requestPending;
  logic [2:0]  requestLevel;
  logic [3:0]  requestSource;
  logic        altVectorTable;
  logic [24:0] ev;
  logic [2:0]  pin;
  logic        hold;
  int          n_mismatch = 0;
  int          n_compared = 0;
  // Flag bit of each event line, in the model's order
  int          bitTab [25] = '{13, 12, 11, 10, 9, 8, 7, 6, 5, 3, 2, 1, 7, 6, 3, 1, 0, 15, 10, 9, 10, 9, 1, 2, 1};
  // Read-back of all-ones per register; bit 14 of reg 1 is not writable
  logic [15:0] maskTab [7] = '{16'h0006, 16'h8007, 16'h3FEF, 16'h20DB, 16'h8600, 16'h0602, 16'h3FEF};

  irq_source_model u_irq_source_model (.sys_clk(sys_clk), .eventLine(ev), .extPinLevel(pin), .holdActive(hold));

  interrupt_flag_enable_bank u_interrupt_flag_enable_bank (
    .sys_clk(sys_clk), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .irqHoldInstrActive(hold), .stackFaultTrap(ev[23]), .clockFailureTrap(ev[24]),
    .ext0Pin(pin[0]), .ext1Pin(pin[1]), .ext2Pin(pin[2]),
    .adcDoneEvent(ev[0]), .uartTxEvent(ev[1]), .uartRxEvent(ev[2]), .spiEvent(ev[3]),
    .spiFaultEvent(ev[4]), .timer3Event(ev[5]), .timer2Event(ev[6]), .compare2Event(ev[7]),
    .capture2Event(ev[8]), .timer1Event(ev[9]), .compare1Event(ev[10]), .capture1Event(ev[11]),
    .capture8Event(ev[12]), .capture7Event(ev[13]), .pinChangeEvent(ev[14]), .i2cMasterEvent(ev[15]),
    .i2cSlaveEvent(ev[16]), .pwm1FaultAEvent(ev[17]), .quadEncoderEvent(ev[18]), .pwm1Event(ev[19]),
    .pwm2FaultAEvent(ev[20]), .pwm2ErrorEvent(ev[21]), .uartErrorEvent(ev[22]),
    .requestPending(requestPending), .requestLevel(requestLevel),
    .requestSource(requestSource), .altVectorTable(altVectorTable)
  );

  // 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Register holding an event line's flag
  function automatic logic [2:0] regOf(input int i);
    return (i < 12) ? 3'h2 : (i < 17) ? 3'h3 : (i < 20) ? 3'h4 : (i < 23) ? 3'h5 : 3'h0;
  endfunction

  // Flag of external input e: ext0 in flags0, ext1 and ext2 in flags1
  function automatic logic [15:0] extMask(input int e);
    return (e == 0) ? 16'h0001 : (e == 1) ? 16'h0010 : 16'h2000;
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t value %h expected %h", $time, seen, exp);
    end
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    regAddr   <= a;
    regWrData <= d;
    regWrEn   <= 1'b1;
    @(posedge sys_clk);
    regWrEn   <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rdchk(input logic [2:0] a, input logic [15:0] exp);
    @(posedge sys_clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge sys_clk);
    regRdEn <= 1'b0;
    @(negedge sys_clk);
    chk(regRdData, exp);
  endtask

  // Request outputs packed as pending, level, source
  task automatic reqchk(input logic [15:0] exp);
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    chk({8'h00, requestPending, requestLevel, requestSource}, exp);
  endtask

  // Pin move, then the synchroniser and flag latency, then read and clear
  task automatic pinchk(input int e, input logic lvl, input logic [15:0] exp);
    u_irq_source_model.set_pin(e, lvl);
    repeat (6) @(posedge sys_clk);
    rdchk((e == 0) ? 3'h2 : 3'h3, exp);
    wr((e == 0) ? 3'h2 : 3'h3, 16'h0000);
  endtask

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Watchdog, well beyond the roughly five hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    end_of_test();
  end

  initial begin
    reset_n   = 1'b0;
    regAddr   = 3'h0;
    regWrData = 16'h0000;
    regWrEn   = 1'b0;
    regRdEn   = 1'b0;
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    // Reset values, then all-ones to expose writable bits
    for (int i = 0; i < 7; i++) begin
      rdchk(3'(i), 16'h0000);
      wr(3'(i), 16'hFFFF);
      rdchk(3'(i), maskTab[i]);
    end
    rdchk(3'h7, 16'h4444);
    reqchk(16'h00C0);
    chk({15'h0000, altVectorTable}, 16'h0001);
    for (int i = 0; i < 7; i++) begin
      wr(3'(i), 16'h0000);
    end
    reqchk(16'h0000);
    chk({15'h0000, altVectorTable}, 16'h0000);
    $display("test masks done");
    // Hold status is live and ignores writes
    @(posedge sys_clk);
    u_irq_source_model.holdActive <= 1'b1;
    wr(3'h1, 16'h0000);
    rdchk(3'h1, 16'h4000);
    @(posedge sys_clk);
    u_irq_source_model.holdActive <= 1'b0;
    rdchk(3'h1, 16'h0000);
    $display("test hold done");
    // Each source sets only its own flag, enables all off
    for (int i = 0; i < 25; i++) begin
      u_irq_source_model.fire(i);
      rdchk(regOf(i), 16'h0001 << bitTab[i]);
      rdchk(regOf(i), 16'h0001 << bitTab[i]);
      wr(regOf(i), 16'h0000);
      rdchk(regOf(i), 16'h0000);
    end
    $display("test sources done");
    // Gating, tie break and priority codes
    u_irq_source_model.fire(9);
    reqchk(16'h0000);
    wr(3'h6, 16'h2008);
    reqchk(16'h00C3);
    u_irq_source_model.fire(0);
    reqchk(16'h00C3);
    wr(3'h7, 16'h0444);
    reqchk(16'h00CD);
    wr(3'h7, 16'h7444);
    reqchk(16'h00F3);
    wr(3'h6, 16'h0000);
    reqchk(16'h0000);
    wr(3'h2, 16'h0000);
    $display("test gating done");
    // Edge polarity per external input
    for (int e = 0; e < 3; e++) begin
      wr(3'h1, 16'h0001 << e);
      pinchk(e, 1'b1, 16'h0000);
      pinchk(e, 1'b0, extMask(e));
      wr(3'h1, 16'h0000);
      pinchk(e, 1'b1, extMask(e));
      pinchk(e, 1'b0, 16'h0000);
    end
    $display("test edges done");
    end_of_test();
  end
endmodule

`default_nettype wire
